// *** core/bors_consts.vh ***
`ifndef BORS_CONSTS_VH
`define BORS_CONSTS_VH
// Register port map (word addresses on the plain register port)
`define BORS_ADDR_RESET_CTRL   4'h0
`define BORS_ADDR_OSC_CTRL     4'h1
`define BORS_ADDR_CFG          4'h2
`define BORS_ADDR_IRQ_STATUS   4'h3
`define BORS_ADDR_IRQ_MASK     4'h4
// Field positions
`define BORS_RESET_CONTROL_REG_DROOP_BIT    1
`define BORS_OSC_LOCK_BIT      5
`define BORS_OSC_READY_BIT     0
`define BORS_OSC_CLKON_BIT     1
`define BORS_CFG_OSEL_LSB      0
`define BORS_CFG_PMODE_LSB     3
`define BORS_CFG_POWERUP_TIMER_EN_BIT   5
`define BORS_IRQ_DROOP_BIT     0
`define BORS_IRQ_RELEASE_BIT   1
// Reset values
`define BORS_CFG_RESET         8'h27
`define BORS_MASK_RESET        2'h0
// Oscillator select encodings (0/1 = internal RC, 2/3 = primary, 1/3 with PLL)
`define BORS_OSEL_FRC          3'h0
`define BORS_OSEL_FRC_PLL      3'h1
`define BORS_OSEL_PRI          3'h2
`define BORS_OSEL_PRI_PLL      3'h3
`define BORS_PMODE_EC          2'h0
`define BORS_PMODE_XT          2'h1
`define BORS_PMODE_HS          2'h2
`define BORS_PMODE_OFF         2'h3
// Timing: clock period in ns, pulse and start-up counts in cycles, other delays in us
`define BORS_CLK_NS            100
`define BORS_PULSE_CYC         16'd4
`define BORS_OST_CYC           16'd1024
`define BORS_POWERUP_TIMER_US           64
`define BORS_FSCM_US           2
`endif

// *** core/bors_sequencer.v ***
// Overview of operation
// - A synchronised droop alarm from the core supply monitor drives a device reset pulse.
// - After a droop reset the clock source is chosen from the oscillator select and primary mode fields.
// - With an oscillator source the start-up timer runs and the system clock stays gated until it expires.
// - With the PLL in use the system clock stays gated until the lock bit reads one.
// - The power-up delay runs alongside the clock hold and internal reset waits for it.
// - With the power-up delay off and a crystal in use, only the fail-safe monitor delay is applied.
// - Every droop reset sets the droop status flag at bit 1 of the reset control register.
// - Detection and reset stay active in sleep and idle and reset the device there too.
//
// Local design decisions: the strobed register port and the register offsets.
`timescale 1ns/1ps
`include "bors_consts.vh"
module bors_sequencer #(
  parameter POWERUP_TIMER_CYC = `BORS_POWERUP_TIMER_US * 1000 / `BORS_CLK_NS,
  parameter FSCM_CYC = `BORS_FSCM_US * 1000 / `BORS_CLK_NS
) (
  input  wire        ref_clk,
  input  wire        nrst,
  input  wire        droop_alarm,
  input  wire        pll_lock,
  input  wire        sleep_mode,
  input  wire        idle_mode,
  input  wire [3:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [7:0]  reg_rdata,
  output wire        supply_droop_reset,
  output wire        internal_reset_n,
  output wire        sysclk_enable,
  output wire        irq
);
  // Sequencer states
  localparam ST_RUN   = 2'h0;
  localparam ST_PULSE = 2'h1;
  localparam ST_HOLD  = 2'h2;

  // Sequencer state and timers
  reg [1:0]  state_r;
  reg [15:0] pulse_cnt_r;
  reg [15:0] ost_cnt_r;
  reg [31:0] powerup_timer_cnt_r;
  reg        ost_done_r;
  reg        powerup_timer_done_r;
  reg        clk_on_r;

  // Software-visible registers
  reg        droop_flag_r;
  reg [7:0]  cfg_r;
  reg [1:0]  irq_stat_r;
  reg [1:0]  irq_mask_r;

  // Synchroniser stages and latched source selection
  reg        alarm_s1_r;
  reg        alarm_s2_r;
  reg        lock_s1_r;
  reg        lock_s2_r;
  reg [2:0]  osel_r;
  reg [1:0]  pmode_r;
  reg        sleep_s1_r;
  reg        sleep_s2_r;
  reg        idle_s1_r;
  reg        idle_s2_r;

  // Source needs a start-up timer when a primary oscillator is running
  function uses_osc;
    input [2:0] osel;
    input [1:0] pmode;
    begin
      uses_osc = ((osel == `BORS_OSEL_PRI) || (osel == `BORS_OSEL_PRI_PLL)) && (pmode != `BORS_PMODE_OFF);
    end
  endfunction

  function uses_pll;
    input [2:0] osel;
    begin
      uses_pll = (osel == `BORS_OSEL_FRC_PLL) || (osel == `BORS_OSEL_PRI_PLL);
    end
  endfunction

  // Properties of the source latched at the end of the last pulse
  wire is_crystal = uses_osc(osel_r, pmode_r) &&
                    ((pmode_r == `BORS_PMODE_XT) || (pmode_r == `BORS_PMODE_HS));
  wire powerup_timer_en    = cfg_r[`BORS_CFG_POWERUP_TIMER_EN_BIT];
  // Delay chosen for the power-up leg; zero delay with crystal falls back to the monitor delay
  wire [31:0] powerup_timer_target = powerup_timer_en ? POWERUP_TIMER_CYC : (is_crystal ? FSCM_CYC : 32'd0);
  wire clk_ready  = (!uses_osc(osel_r, pmode_r) || ost_done_r) &&
                    (!uses_pll(osel_r) || lock_s2_r);
  wire seq_done   = clk_ready && powerup_timer_done_r;
  wire release_ev = (state_r == ST_HOLD) && seq_done;

  // Two-stage synchronisers for pins from outside the clock domain
  // Only the second stage is read; the two cycles of latency merely delay
  // the reset pulse and the lock wait, which no rule bounds that tightly
  always @(posedge ref_clk) begin
    if (!nrst) begin
      alarm_s1_r <= 1'b0;
      alarm_s2_r <= 1'b0;
      lock_s1_r  <= 1'b0;
      lock_s2_r  <= 1'b0;
      sleep_s1_r <= 1'b0;
      sleep_s2_r <= 1'b0;
      idle_s1_r  <= 1'b0;
      idle_s2_r  <= 1'b0;
    end else begin
      alarm_s1_r <= droop_alarm;
      alarm_s2_r <= alarm_s1_r;
      lock_s1_r  <= pll_lock;
      lock_s2_r  <= lock_s1_r;
      sleep_s1_r <= sleep_mode;
      sleep_s2_r <= sleep_s1_r;
      idle_s1_r  <= idle_mode;
      idle_s2_r  <= idle_s1_r;
    end
  end

  // Sequence after a droop alarm:
  //   pulse - reset output high for a fixed count, restarted while the alarm stays up
  //   hold  - start-up timer, lock wait and power-up delay run side by side
  //   run   - internal reset released once the power-up delay and the source's clock waits are met; the clock comes on in hold once those waits are met
  // The alarm is a level: a supply that stays low keeps the device in the pulse
  // state, so the hold phase never begins on a sagging supply.
  // Source selection is latched as the pulse ends; a source or mode write during the
  // hold phase takes effect only at the next droop reset, but the power-up delay enable bit acts at once.
  // Limitation: the start-up count is in reference clock cycles, not oscillator
  // cycles, so it bounds the wait without proving that the oscillator runs.

  // Next values of the sequencer registers
  reg [1:0]  state_nxt;
  reg [15:0] pulse_cnt_nxt;
  reg [15:0] ost_cnt_nxt;
  reg [31:0] powerup_timer_cnt_nxt;
  reg        ost_done_nxt;
  reg        powerup_timer_done_nxt;
  reg        clk_on_nxt;
  reg [2:0]  osel_nxt;
  reg [1:0]  pmode_nxt;

  // Last count of the pulse and start-up timers, sized to their counters so the compares stay narrow
  localparam [15:0] PULSE_LAST = `BORS_PULSE_CYC - 16'd1;
  localparam [15:0] OST_LAST   = `BORS_OST_CYC - 16'd1;

  // Sequencer next state; low-power modes do not gate detection, so a droop in sleep or idle still resets
  always @* begin
    state_nxt     = state_r;
    pulse_cnt_nxt = pulse_cnt_r;
    ost_cnt_nxt   = ost_cnt_r;
    powerup_timer_cnt_nxt  = powerup_timer_cnt_r;
    ost_done_nxt  = ost_done_r;
    powerup_timer_done_nxt = powerup_timer_done_r;
    clk_on_nxt    = clk_on_r;
    osel_nxt      = osel_r;
    pmode_nxt     = pmode_r;
    if (alarm_s2_r) begin
      // Alarm restarts the whole pulse regardless of sleep or idle
      state_nxt     = ST_PULSE;
      pulse_cnt_nxt = 16'h0000;
      clk_on_nxt    = 1'b0;
    end else begin
      case (state_r)
        ST_RUN: begin
          clk_on_nxt = 1'b1;
        end
        ST_PULSE: begin
          if (pulse_cnt_r == PULSE_LAST) begin
            // Latch source selection at the end of the pulse
            osel_nxt      = cfg_r[`BORS_CFG_OSEL_LSB +: 3];
            pmode_nxt     = cfg_r[`BORS_CFG_PMODE_LSB +: 2];
            ost_cnt_nxt   = 16'h0000;
            powerup_timer_cnt_nxt  = 32'h00000000;
            ost_done_nxt  = 1'b0;
            powerup_timer_done_nxt = 1'b0;
            state_nxt     = ST_HOLD;
          end else begin
            pulse_cnt_nxt = pulse_cnt_r + 16'd1;
          end
        end
        ST_HOLD: begin
          // Start-up timer and power-up timer run concurrently
          if (!ost_done_r) begin
            if (ost_cnt_r == OST_LAST)
              ost_done_nxt = 1'b1;
            else
              ost_cnt_nxt = ost_cnt_r + 16'd1;
          end
          if (!powerup_timer_done_r) begin
            if (powerup_timer_cnt_r >= powerup_timer_target)
              powerup_timer_done_nxt = 1'b1;
            else
              powerup_timer_cnt_nxt = powerup_timer_cnt_r + 32'd1;
          end
          if (clk_ready)
            clk_on_nxt = 1'b1;
          if (release_ev)
            state_nxt = ST_RUN;
        end
        default: begin
          state_nxt = ST_RUN;
        end
      endcase
    end
  end

  // Sequencer registers; nrst leaves the clock running and the device out of reset
  // so that a plain power-on does not look like a droop to software
  always @(posedge ref_clk) begin
    if (!nrst) begin
      state_r     <= ST_RUN;
      pulse_cnt_r <= 16'h0000;
      ost_cnt_r   <= 16'h0000;
      powerup_timer_cnt_r  <= 32'h00000000;
      ost_done_r  <= 1'b0;
      powerup_timer_done_r <= 1'b0;
      clk_on_r    <= 1'b1;
      osel_r      <= 3'h0;
      pmode_r     <= 2'h0;
    end else begin
      state_r     <= state_nxt;
      pulse_cnt_r <= pulse_cnt_nxt;
      ost_cnt_r   <= ost_cnt_nxt;
      powerup_timer_cnt_r  <= powerup_timer_cnt_nxt;
      ost_done_r  <= ost_done_nxt;
      powerup_timer_done_r <= powerup_timer_done_nxt;
      clk_on_r    <= clk_on_nxt;
      osel_r      <= osel_nxt;
      pmode_r     <= pmode_nxt;
    end
  end

  // Reset outputs decode the state; the interrupt is a level while any unmasked status bit is set
  assign supply_droop_reset = (state_r == ST_PULSE);
  assign internal_reset_n   = (state_r == ST_RUN);
  assign sysclk_enable      = clk_on_r;
  assign irq                = |(irq_stat_r & irq_mask_r);

  // A droop event is the first alarm cycle; a held alarm counts once
  wire droop_ev = alarm_s2_r && (state_r != ST_PULSE);

  // Register map on the plain port (8-bit words):
  //   0 reset control  bit 1 droop flag, write zero to clear
  //   1 oscillator     read only: bit 5 lock, bit 3 idle, bit 2 sleep, bit 1 clock on, bit 0 clock ready
  //   2 configuration  bits 2:0 source, bits 4:3 primary mode, bit 5 power-up delay enable
  //   3 irq status     bit 0 droop, bit 1 release, write one to clear
  //   4 irq mask       same layout as status
  // Writes to other addresses are ignored and reads of them return zero.

  // True when a write strobe lands on the given register address
  function wr_hit;
    input       wr;
    input [3:0] addr;
    input [3:0] sel;
    begin
      wr_hit = wr && (addr == sel);
    end
  endfunction

  // One write decode per writable register
  wire wr_rst_ctrl = wr_hit(reg_wr, reg_addr, `BORS_ADDR_RESET_CTRL);
  wire wr_cfg      = wr_hit(reg_wr, reg_addr, `BORS_ADDR_CFG);
  wire wr_status   = wr_hit(reg_wr, reg_addr, `BORS_ADDR_IRQ_STATUS);
  wire wr_mask     = wr_hit(reg_wr, reg_addr, `BORS_ADDR_IRQ_MASK);

  // Events that set the status bits, placed at their bit positions
  wire [1:0] irq_ev;
  assign irq_ev[`BORS_IRQ_DROOP_BIT]   = droop_ev;
  assign irq_ev[`BORS_IRQ_RELEASE_BIT] = release_ev;

  // Write-one-to-clear status; an event in the same cycle as the clear wins so none is lost
  wire [1:0] irq_stat_nxt;
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_irq_stat
      assign irq_stat_nxt[g] = irq_ev[g] || (irq_stat_r[g] && !(wr_status && reg_wdata[g]));
    end
  endgenerate

  // Droop flag is not touched by the reset it causes, and a set beats a clear
  reg       droop_flag_nxt;
  reg [7:0] cfg_nxt;
  reg [1:0] irq_mask_nxt;
  always @* begin
    droop_flag_nxt = droop_flag_r;
    cfg_nxt        = cfg_r;
    irq_mask_nxt   = irq_mask_r;
    if (droop_ev)
      droop_flag_nxt = 1'b1;
    else if (wr_rst_ctrl && !reg_wdata[`BORS_RESET_CONTROL_REG_DROOP_BIT])
      droop_flag_nxt = 1'b0;
    if (wr_cfg)
      cfg_nxt = reg_wdata;
    if (wr_mask)
      irq_mask_nxt = reg_wdata[1:0];
  end

  // Register update; configuration returns to its reset value only on nrst
  always @(posedge ref_clk) begin
    if (!nrst) begin
      droop_flag_r <= 1'b0;
      cfg_r        <= `BORS_CFG_RESET;
      irq_stat_r   <= 2'h0;
      irq_mask_r   <= `BORS_MASK_RESET;
    end else begin
      droop_flag_r <= droop_flag_nxt;
      cfg_r        <= cfg_nxt;
      irq_stat_r   <= irq_stat_nxt;
      irq_mask_r   <= irq_mask_nxt;
    end
  end

  // Read data one cycle after the strobe; unmapped addresses and idle cycles read zero
  // Reads have no side effects, so software may poll any register freely
  reg [7:0] rdata_nxt;
  always @* begin
    rdata_nxt = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        `BORS_ADDR_RESET_CTRL: rdata_nxt = {6'h00, droop_flag_r, 1'b0};
        `BORS_ADDR_OSC_CTRL:   rdata_nxt = {2'h0, lock_s2_r, 1'b0, idle_s2_r, sleep_s2_r, clk_on_r, clk_ready};
        `BORS_ADDR_CFG:        rdata_nxt = cfg_r;
        `BORS_ADDR_IRQ_STATUS: rdata_nxt = {6'h00, irq_stat_r};
        `BORS_ADDR_IRQ_MASK:   rdata_nxt = {6'h00, irq_mask_r};
        default:               rdata_nxt = 8'h00;
      endcase
    end
  end

  // Read data register; data outputs come from flip-flops
  always @(posedge ref_clk) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= rdata_nxt;
    end
  end
endmodule // bors_sequencer

// *** testbench/bors_sequencer_properties.sv ***
`timescale 1ns/1ps
module bors_sequencer_properties #(
  parameter POWERUP_TIMER_CYC = 640,
  parameter FSCM_CYC = 20
) (
  input wire       ref_clk,
  input wire       nrst,
  input wire       droop_alarm,
  input wire       pll_lock,
  input wire       sleep_mode,
  input wire       idle_mode,
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire       reg_wr,
  input wire       reg_rd,
  input wire [7:0] reg_rdata,
  input wire       supply_droop_reset,
  input wire       internal_reset_n,
  input wire       sysclk_enable,
  input wire       irq
);
  reg [7:0]  cfg_r;
  reg [11:0] cnt_r;
  // Shadow of the config and cycles since the pulse ended
  always @(posedge ref_clk) begin
    if (!nrst) cfg_r <= 8'h27;
    else if (reg_wr && reg_addr == 4'h2) cfg_r <= reg_wdata;
    if (!nrst || supply_droop_reset) cnt_r <= 12'h0;
    else if (cnt_r != 12'hfff) cnt_r <= cnt_r + 12'h1;
  end
  // EC is left out: only crystals surely need the start-up wait
  wire xo_w = cfg_r[1] && (cfg_r[4:3] == 2'h1 || cfg_r[4:3] == 2'h2);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  AST_DROOP_RESP: assert property ($rose(droop_alarm) |-> ##3 supply_droop_reset)
    else $error("droop reset late");
  AST_PULSE_HOLD: assert property (supply_droop_reset |-> !internal_reset_n && !sysclk_enable)
    else $error("pulse without hold");
  AST_PULSE_LEN: assert property ($rose(supply_droop_reset) |-> supply_droop_reset[*4])
    else $error("pulse short");
  AST_SLEEP_DET: assert property ($rose(droop_alarm) && (sleep_mode || idle_mode) |-> ##3 supply_droop_reset)
    else $error("no reset in low power");
  AST_OST_WAIT: assert property ($rose(sysclk_enable) && xo_w |-> cnt_r >= 12'd1023)
    else $error("clock before start-up");
  AST_PLL_WAIT: assert property ($rose(sysclk_enable) && cfg_r[0] |-> $past(pll_lock, 2))
    else $error("clock before lock");
  AST_POWERUP_TIMER_WAIT: assert property ($rose(internal_reset_n) && cfg_r[5] |-> cnt_r >= POWERUP_TIMER_CYC - 1)
    else $error("release before delay");
  AST_FSCM_WAIT: assert property ($rose(internal_reset_n) && !cfg_r[5] && xo_w |-> cnt_r >= FSCM_CYC - 1)
    else $error("release before monitor delay");
  cover property ($rose(internal_reset_n));
  cover property ($rose(supply_droop_reset) && sleep_mode);
  cover property ($fell(irq));
endmodule // bors_sequencer_properties
bind bors_sequencer bors_sequencer_properties #(.POWERUP_TIMER_CYC(POWERUP_TIMER_CYC), .FSCM_CYC(FSCM_CYC)) bors_sequencer_properties_inst (
  .ref_clk, .nrst, .droop_alarm, .pll_lock, .sleep_mode, .idle_mode, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .supply_droop_reset, .internal_reset_n, .sysclk_enable, .irq);

// *** testbench/tb_brownout_reset_sequencer.sv ***
`timescale 1ns/1ps
module tb_brownout_reset_sequencer;
  reg ref_clk = 0, nrst = 0, droop_alarm = 0, pll_lock = 0, sleep_mode = 0, idle_mode = 0;
  reg reg_wr = 0, reg_rd = 0, rd_d = 0;
  reg [3:0] reg_addr = 4'h0;
  reg [7:0] reg_wdata = 8'h0, cfg;
  wire [7:0] reg_rdata;
  wire supply_droop_reset, internal_reset_n, sysclk_enable, irq;
  integer num_errors = 0, checks = 0, seed = 32'h9625, i, n;
  reg [7:0] q[$];
  // FRC, FRC+PLL, XT without power-up delay, HS+PLL, EC
  localparam [39:0] CFGS = 40'h22_33_0a_01_20;
  always #50 ref_clk = ~ref_clk;
  bors_sequencer #(.POWERUP_TIMER_CYC(8), .FSCM_CYC(2)) bors_sequencer_inst (
    .ref_clk, .nrst, .droop_alarm, .pll_lock, .sleep_mode, .idle_mode, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .supply_droop_reset, .internal_reset_n, .sysclk_enable, .irq);
  task chk(input [7:0] e, input [7:0] s, input [63:0] nm);
    checks++;
    if (s !== e) begin
      num_errors++;
      $display("[FAIL] %0s expected %h seen %h", nm, e, s);
    end
  endtask
  task wr(input [3:0] a, input [7:0] d);
    @(posedge ref_clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge ref_clk) reg_wr <= 1'b0;
  endtask
  // Expected data waits in the queue until the answer cycle
  task rd(input [3:0] a, input [7:0] e);
    q.push_back(e);
    @(posedge ref_clk) {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge ref_clk) reg_rd <= 1'b0;
  endtask
  always @(posedge ref_clk) begin
    if (rd_d) chk(q.pop_front(), reg_rdata, "rdata");
    rd_d <= reg_rd;
  end
  task results;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #(100 * 20000);
    num_errors++;
    results;
  end
  initial begin
    repeat (3) @(posedge ref_clk);
    nrst <= 1'b1;
    rd(4'h2, 8'h27);
    rd(4'h4, 8'h00);
    rd(4'hf, 8'h00);
    for (i = 0; i < 5; i++) begin
      cfg = CFGS[i*8+:8];
      wr(4'h4, i ? 8'h03 : 8'h00);
      wr(4'h2, cfg);
      {idle_mode, sleep_mode, pll_lock} <= {i[1:0], 1'b0};
      @(posedge ref_clk) droop_alarm <= 1'b1;
      n = $random(seed) & 3;
      repeat (n + 1) @(posedge ref_clk);
      droop_alarm <= 1'b0;
      repeat (1100) @(posedge ref_clk);
      chk({sysclk_enable, internal_reset_n}, cfg[0] ? 8'h0 : 8'h3, "hold");
      pll_lock <= 1'b1;
      for (n = 0; !internal_reset_n && n < 100; n++) @(posedge ref_clk);
      chk(internal_reset_n, 8'h1, "rel");
      rd(4'h0, 8'h02);
      rd(4'h1, {2'h0, 1'b1, 1'b0, i[1:0], 2'h3});
      chk(irq, i ? 8'h1 : 8'h0, "irq");
      wr(4'h3, 8'h03);
      @(posedge ref_clk) chk(irq, 8'h0, "irqclr");
      wr(4'h0, 8'h00);
      rd(4'h0, 8'h00);
      $display("test %0d done", i);
    end
    repeat (2) @(posedge ref_clk);
    results;
  end
endmodule // tb_brownout_reset_sequencer
